/* ib2_irq_bank.sv */
/*
  Second interrupt bank: sticky write-one-to-clear flags for twelve
  headphone short conditions, boot complete and the always-on group,
  per-flag masks, a global output mask and a registered interrupt line.
  Assumes an APB master on i_clk and detection levels synchronous to it.
*/
// Added by the designer: register access over APB.
module ib2_irq_bank #(
  parameter int ADDR_W = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [ib2_pkg::NUM_SHORT-1:0] i_short_det,
  input wire logic i_boot_done,
  input wire logic i_mic_clamp,
  input wire logic i_gpin_five,
  input wire logic i_jack_detect,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq
);

  // register decode, used by both read mux and error answer
  function automatic logic ib2_known(input logic [ib2_pkg::IDX_W-1:0] a);
    ib2_known = (a == ib2_pkg::IDX_BOOT_FLAGS) || (a == ib2_pkg::IDX_SHORT_FLAGS) ||
                ((a >= ib2_pkg::IDX_MASK_FIRST) && (a <= ib2_pkg::IDX_MASK_LAST)) ||
                (a == ib2_pkg::IDX_OUT_CTRL) || (a == ib2_pkg::IDX_AON_FLAGS) ||
                (a == ib2_pkg::IDX_AON_MASK);
  endfunction

  // reset value of each main mask register
  function automatic logic [ib2_pkg::REG_W-1:0] ib2_mask_rst(input int n);
    ib2_mask_rst = (n == ib2_pkg::BOOT_MASK_REG) ? ib2_pkg::BOOT_MASK_RST
                                                 : ib2_pkg::MASK_RST;
  endfunction

  localparam int NM = ib2_pkg::NUM_MASK;
  localparam int NS = ib2_pkg::NUM_SHORT;
  localparam int NA = ib2_pkg::AON_N;

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  logic [NS-1:0] short_ff;
  logic boot_ff;
  logic [NA-1:0] aon_ff;
  logic [NA-1:0] aon_mask_ff;
  logic gmask_ff;
  logic [ib2_pkg::REG_W-1:0] mask_ff [NM];
  logic [ib2_pkg::REG_W-1:0] nxt_mask [NM];

  // edge detection on all condition levels
  ib2_edge_if #(.W(ib2_pkg::EV_W)) ev_if ();

  assign ev_if.level = {i_jack_detect, i_gpin_five, i_mic_clamp, i_boot_done, i_short_det};

  ib2_edge_det #(.W(ib2_pkg::EV_W)) u_edge (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .ev(ev_if.det)
  );

  // bus decode; one wait state, so writes land on the completing edge
  logic [ib2_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic mapped;
  logic access;
  logic first_acc;
  logic done;
  logic wr_en;
  logic in_mask;
  logic [2:0] mask_sel;
  logic [15:0] wdata;

  assign idx = i_paddr[13:2];
  assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:14] == '0);
  assign mapped = aligned && ib2_known(idx);
  assign access = i_psel && i_penable;
  assign first_acc = access && !pready_ff;
  assign done = access && pready_ff;
  assign wr_en = done && i_pwrite && mapped;
  assign wdata = i_pwdata[15:0];
  assign in_mask = (idx >= ib2_pkg::IDX_MASK_FIRST) && (idx <= ib2_pkg::IDX_MASK_LAST);
  assign mask_sel = 3'(idx - ib2_pkg::IDX_MASK_FIRST);

  // per-register write strobes
  logic wr_boot;
  logic wr_short;
  logic wr_ctrl;
  logic wr_aon;
  logic wr_aon_mask;

  assign wr_boot = wr_en && (idx == ib2_pkg::IDX_BOOT_FLAGS);
  assign wr_short = wr_en && (idx == ib2_pkg::IDX_SHORT_FLAGS);
  assign wr_ctrl = wr_en && (idx == ib2_pkg::IDX_OUT_CTRL);
  assign wr_aon = wr_en && (idx == ib2_pkg::IDX_AON_FLAGS);
  assign wr_aon_mask = wr_en && (idx == ib2_pkg::IDX_AON_MASK);

  // event sets; always-on order is fall above rise per source
  logic [NS-1:0] short_set;
  logic boot_set;
  logic [NA-1:0] aon_set;

  assign short_set = ev_if.rise[NS-1:0];
  assign boot_set = ev_if.rise[ib2_pkg::EV_BOOT];
  assign aon_set = {ev_if.fall[ib2_pkg::EV_CLAMP], ev_if.rise[ib2_pkg::EV_CLAMP],
                    ev_if.fall[ib2_pkg::EV_GPIN], ev_if.rise[ib2_pkg::EV_GPIN],
                    ev_if.fall[ib2_pkg::EV_JACK], ev_if.rise[ib2_pkg::EV_JACK]};

  // write-one clears; a set in the same cycle wins over the clear
  logic [NS-1:0] nxt_short;
  logic nxt_boot;
  logic [NA-1:0] nxt_aon;

  assign nxt_short = (short_ff & ~(wr_short ? wdata[NS-1:0] : '0)) | short_set;
  assign nxt_boot = (boot_ff & ~(wr_boot && wdata[ib2_pkg::BOOT_BIT])) | boot_set;
  assign nxt_aon = (aon_ff & ~(wr_aon ? wdata[ib2_pkg::AON_LSB +: NA] : '0)) | aon_set;

  // sticky flags
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      short_ff <= '0;
      boot_ff <= 1'b0;
      aon_ff <= '0;
    end else begin
      short_ff <= nxt_short;
      boot_ff <= nxt_boot;
      aon_ff <= nxt_aon;
    end
  end

  // main mask array of six registers; only BOOT_MASK_REG and SHORT_MASK_REG gate flags
  for (genvar g = 0; g < NM; g++) begin : g_mask
    assign nxt_mask[g] = (wr_en && in_mask && (mask_sel == 3'(g))) ? wdata : mask_ff[g];
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        mask_ff[g] <= ib2_mask_rst(g);
      end else begin
        mask_ff[g] <= nxt_mask[g];
      end
    end
  end

  // always-on mask and global output mask
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      aon_mask_ff <= ib2_pkg::AON_MASK_RST;
      gmask_ff <= ib2_pkg::GMASK_RST;
    end else begin
      aon_mask_ff <= wr_aon_mask ? wdata[ib2_pkg::AON_LSB +: NA] : aon_mask_ff;
      gmask_ff <= wr_ctrl ? wdata[ib2_pkg::GMASK_BIT] : gmask_ff;
    end
  end

  // unmasked pending; masked flags still record, they just stay quiet
  logic pend;
  logic nxt_irq;

  assign pend = (boot_ff && !mask_ff[ib2_pkg::BOOT_MASK_REG][ib2_pkg::BOOT_BIT]) ||
                (|(short_ff & ~mask_ff[ib2_pkg::SHORT_MASK_REG][NS-1:0])) ||
                (|(aon_ff & ~aon_mask_ff));
  assign nxt_irq = pend && !gmask_ff;

  // read mux; unimplemented bits read zero
  logic [15:0] rd_word;

  assign rd_word =
    (idx == ib2_pkg::IDX_BOOT_FLAGS) ? 16'(32'(boot_ff) << ib2_pkg::BOOT_BIT) :
    (idx == ib2_pkg::IDX_SHORT_FLAGS) ? 16'(short_ff) :
    in_mask ? mask_ff[mask_sel] :
    (idx == ib2_pkg::IDX_OUT_CTRL) ? 16'(gmask_ff) :
    (idx == ib2_pkg::IDX_AON_FLAGS) ? 16'(32'(aon_ff) << ib2_pkg::AON_LSB) :
    (idx == ib2_pkg::IDX_AON_MASK) ? 16'(32'(aon_mask_ff) << ib2_pkg::AON_LSB) :
    16'h0000;

  // bus answer, registered so every output comes from a flop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
    end else begin
      pready_ff <= first_acc;
      pslverr_ff <= first_acc && !mapped;
      prdata_ff <= (first_acc && !i_pwrite && mapped) ? {16'h0000, rd_word} : 32'h0000_0000;
      irq_ff <= nxt_irq;
    end
  end

  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;
  assign o_irq = irq_ff;

  // checking helpers: an independent copy of the delayed levels
  logic [ib2_pkg::EV_W-1:0] chk_prev_ff;
  logic [NS-1:0] chk_short_rise;
  logic chk_jack_rise;
  logic chk_jack_fall;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chk_prev_ff <= '0;
    end else begin
      chk_prev_ff <= ev_if.level;
    end
  end

  assign chk_short_rise = i_short_det & ~chk_prev_ff[NS-1:0];
  assign chk_jack_rise = i_jack_detect && !chk_prev_ff[ib2_pkg::EV_JACK];
  assign chk_jack_fall = !i_jack_detect && chk_prev_ff[ib2_pkg::EV_JACK];

  // the other always-on sources and boot, worked out apart from the bank
  logic chk_clamp_rise;
  logic chk_clamp_fall;
  logic chk_gpin_rise;
  logic chk_gpin_fall;
  logic chk_boot_rise;

  assign chk_clamp_rise = i_mic_clamp && !chk_prev_ff[ib2_pkg::EV_CLAMP];
  assign chk_clamp_fall = !i_mic_clamp && chk_prev_ff[ib2_pkg::EV_CLAMP];
  assign chk_gpin_rise = i_gpin_five && !chk_prev_ff[ib2_pkg::EV_GPIN];
  assign chk_gpin_fall = !i_gpin_five && chk_prev_ff[ib2_pkg::EV_GPIN];
  assign chk_boot_rise = i_boot_done && !chk_prev_ff[ib2_pkg::EV_BOOT];

  // write step and jack edges seen by the checks
  sequence s_wr_short_clr0;
    wr_short && i_pwdata[0] && !short_set[0];
  endsequence

  sequence s_jack_rise;
    chk_jack_rise;
  endsequence

  sequence s_jack_fall;
    chk_jack_fall;
  endsequence

  // boot rise with no bus write in flight and nothing blocking it
  sequence s_boot_rise_open;
    chk_boot_rise && !wr_en && !gmask_ff &&
      !mask_ff[ib2_pkg::BOOT_MASK_REG][ib2_pkg::BOOT_BIT];
  endsequence

  property p_short_set;
    @(posedge i_clk) disable iff (i_srst)
      (|chk_short_rise) |=> ((short_ff & $past(chk_short_rise)) == $past(chk_short_rise));
  endproperty
  a_short_set: assert property (p_short_set) else $error("short flag missed a rise");

  property p_sticky;
    @(posedge i_clk) disable iff (i_srst)
      (short_ff[0] && !wr_short) |=> short_ff[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("short flag dropped without write");

  property p_w1c;
    @(posedge i_clk) disable iff (i_srst)
      s_wr_short_clr0 |=> !short_ff[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_mask_store;
    @(posedge i_clk) disable iff (i_srst)
      (wr_en && in_mask) |=> (mask_ff[$past(mask_sel)] == $past(wdata));
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("mask write not stored");

  property p_irq_follow;
    @(posedge i_clk) disable iff (i_srst)
      (pend && !gmask_ff) |=> o_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("unmasked flag gave no irq");

  property p_irq_quiet;
    @(posedge i_clk) disable iff (i_srst)
      (!pend || gmask_ff) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without unmasked flag");

  property p_mask_reset;
    @(posedge i_clk)
      i_srst |=> (mask_ff[ib2_pkg::BOOT_MASK_REG] == ib2_pkg::BOOT_MASK_RST) &&
                 (mask_ff[0] == ib2_pkg::MASK_RST) &&
                 (mask_ff[ib2_pkg::SHORT_MASK_REG] == ib2_pkg::MASK_RST);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("main mask reset wrong");

  property p_gmask;
    @(posedge i_clk)
      i_srst |=> !gmask_ff;
  endproperty
  a_gmask: assert property (p_gmask) else $error("global mask reset wrong");

  property p_gmask_block;
    @(posedge i_clk) disable iff (i_srst)
      gmask_ff [*2] |-> !o_irq;
  endproperty
  a_gmask_block: assert property (p_gmask_block) else $error("irq while blocked");

  property p_aon_mask_reset;
    @(posedge i_clk)
      i_srst |=> (aon_mask_ff == ib2_pkg::AON_MASK_RST);
  endproperty
  a_aon_mask_reset: assert property (p_aon_mask_reset) else $error("aon mask reset wrong");

  property p_jack_rise;
    @(posedge i_clk) disable iff (i_srst)
      s_jack_rise |=> aon_ff[0];
  endproperty
  a_jack_rise: assert property (p_jack_rise) else $error("jack rise flag missed");

  property p_jack_fall;
    @(posedge i_clk) disable iff (i_srst)
      s_jack_fall |=> aon_ff[1] ##1 (aon_ff[1] || $past(wr_aon));
  endproperty
  a_jack_fall: assert property (p_jack_fall) else $error("jack fall flag missed");

  // aon_ff bit n is register bit n plus two
  property p_clamp_rise;
    @(posedge i_clk) disable iff (i_srst)
      chk_clamp_rise |=> aon_ff[4];
  endproperty
  a_clamp_rise: assert property (p_clamp_rise) else $error("clamp rise flag missed");

  property p_clamp_fall;
    @(posedge i_clk) disable iff (i_srst)
      chk_clamp_fall |=> aon_ff[5];
  endproperty
  a_clamp_fall: assert property (p_clamp_fall) else $error("clamp fall flag missed");

  property p_gpin_rise;
    @(posedge i_clk) disable iff (i_srst)
      chk_gpin_rise |=> aon_ff[2];
  endproperty
  a_gpin_rise: assert property (p_gpin_rise) else $error("gpin rise flag missed");

  property p_gpin_fall;
    @(posedge i_clk) disable iff (i_srst)
      chk_gpin_fall |=> aon_ff[3];
  endproperty
  a_gpin_fall: assert property (p_gpin_fall) else $error("gpin fall flag missed");

  property p_boot_irq;
    @(posedge i_clk) disable iff (i_srst)
      s_boot_rise_open |=> ##1 o_irq;
  endproperty
  a_boot_irq: assert property (p_boot_irq) else $error("boot flag gave no irq");

  property p_w1c_keep;
    @(posedge i_clk) disable iff (i_srst)
      (wr_short && !i_pwdata[1] && short_ff[1]) |=> short_ff[1];
  endproperty
  a_w1c_keep: assert property (p_w1c_keep) else $error("write zero cleared flag");

endmodule

/* ib2_pkg.sv */
/*
  Constants for the second interrupt bank: register indices, field
  positions, reset values and event vector layout.
  Assumes registers are reached over a 32-bit APB slave, byte address four
  times the register index.
*/
package ib2_pkg;

  localparam int REG_W = 16;
  localparam int IDX_W = 12;

  // register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_BOOT_FLAGS = 12'hd14;
  localparam logic [IDX_W-1:0] IDX_SHORT_FLAGS = 12'hd15;
  localparam logic [IDX_W-1:0] IDX_MASK_FIRST = 12'hd18;
  localparam logic [IDX_W-1:0] IDX_MASK_LAST = 12'hd1d;
  localparam logic [IDX_W-1:0] IDX_OUT_CTRL = 12'hd1f;
  localparam logic [IDX_W-1:0] IDX_AON_FLAGS = 12'hd52;
  localparam logic [IDX_W-1:0] IDX_AON_MASK = 12'hd54;

  localparam int NUM_MASK = 6;
  localparam int NUM_SHORT = 12;

  // boot-complete flag position and which mask register covers it
  localparam int BOOT_BIT = 8;
  localparam int BOOT_MASK_REG = 4;
  localparam int SHORT_MASK_REG = 5;

  // always-on flags occupy bits 7..2
  localparam int AON_LSB = 2;
  localparam int AON_N = 6;
  localparam int GMASK_BIT = 0;

  // reset values
  localparam logic [REG_W-1:0] MASK_RST = 16'hffff;
  localparam logic [REG_W-1:0] BOOT_MASK_RST = 16'hfeff;
  localparam logic [AON_N-1:0] AON_MASK_RST = 6'h3f;
  localparam logic GMASK_RST = 1'b0;

  // event vector layout shared by edge detector and bank
  localparam int EV_W = 16;
  localparam int EV_BOOT = 12;
  localparam int EV_CLAMP = 13;
  localparam int EV_GPIN = 14;
  localparam int EV_JACK = 15;

endpackage

/* ib2_edge_if.sv */
/*
  Interface carrying detection levels and their edge pulses between the
  bank and its edge detector.
  Assumes both ends run on the same clock.
*/
interface ib2_edge_if #(parameter int W = 16);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport det (input level, output rise, output fall);
  modport use_side (output level, input rise, input fall);
endinterface

/* ib2_edge_det.sv */
/*
  Edge detector: one-cycle rise and fall pulses per level bit.
  Assumes levels are synchronous to i_clk.
*/
module ib2_edge_det #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  ib2_edge_if.det ev
);

  logic [W-1:0] prev_ff;

  // previous level; a level high out of reset counts as a rise
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= ev.level;
    end
  end

  // pulses are combinational so flags set at the next edge
  assign ev.rise = ev.level & ~prev_ff;
  assign ev.fall = ~ev.level & prev_ff;

endmodule

/* ib2_host_model.sv */
/*
  Host model for the second interrupt output: samples the line each clock
  and counts new requests.
  Assumes the line is a registered level on the same clock as the bank.
*/
module ib2_host_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_irq,
  output logic [7:0] o_irq_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic irq_ff;

  // count rising edges only, a level held high is one request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_ff <= 1'b0;
      o_irq_cnt <= 8'h00;
    end else begin
      irq_ff <= i_irq;
      if (i_irq && !irq_ff) begin
        o_irq_cnt <= o_irq_cnt + 8'h01;
      end
    end
  end
endmodule

/* testbench.sv */
/*
  Self-checking bench for the second interrupt bank: apb read and write
  tasks, detection levels, and a host model on the interrupt line.
  Assumes one 200 MHz clock and a synchronous active-high reset.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [11:0] short_det = 12'h000;
  logic boot = 1'b0;
  logic [2:0] aon = 3'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic irq;
  logic err;
  logic [7:0] irq_cnt;
  logic [31:0] aon_exp;
  int error_cnt = 0;
  int comparisons = 0;

  ib2_irq_bank uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_short_det(short_det), .i_boot_done(boot),
    .i_mic_clamp(aon[2]), .i_gpin_five(aon[1]), .i_jack_detect(aon[0]),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq)
  );

  ib2_host_model host (.i_clk(i_clk), .i_srst(i_srst), .i_irq(irq), .o_irq_cnt(irq_cnt));

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) begin
      @(posedge i_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    check("wait_states", n, 32'h1);
    @(posedge i_clk);
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 16'h0000);
    check("rdata", rd, exp);
    check("slverr", {31'h0, err}, 32'h0);
  endtask

  // edge seen, flag, then line: four edges covers the whole path
  task automatic irqchk(input logic exp);
    repeat (4) @(posedge i_clk);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    // reset values of masks, control and flags
    for (int i = 0; i < 6; i++) begin
      rdchk(12'hd18 + 12'(i), (i == 4) ? 32'h0000feff : 32'h0000ffff);
    end
    rdchk(12'hd54, 32'h000000fc);
    rdchk(12'hd1f, 32'h00000000);
    rdchk(12'hd15, 32'h00000000);
    // unmapped index is refused with an error and zero data
    xfer(1'b0, 12'hd10, 16'h0000);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_rd", rd, 32'h0);
    // boot flag is unmasked out of reset
    boot <= 1'b1;
    irqchk(1'b1);
    rdchk(12'hd14, 32'h00000100);
    xfer(1'b1, 12'hd14, 16'h0000);
    irqchk(1'b1);
    xfer(1'b1, 12'hd14, 16'h0100);
    irqchk(1'b0);
    // all short flags record while masked
    short_det <= 12'hfff;
    irqchk(1'b0);
    rdchk(12'hd15, 32'h00000fff);
    xfer(1'b1, 12'hd1d, 16'hfffe);
    irqchk(1'b1);
    // global mask blocks the line, lifting it restores it
    xfer(1'b1, 12'hd1f, 16'h0001);
    irqchk(1'b0);
    rdchk(12'hd1f, 32'h00000001);
    xfer(1'b1, 12'hd1f, 16'h0000);
    irqchk(1'b1);
    // clear while the level stays high: no new rise, flag stays clear
    xfer(1'b1, 12'hd15, 16'h0001);
    irqchk(1'b0);
    rdchk(12'hd15, 32'h00000ffe);
    // pulse jack, gpin, clamp in turn: each sets both edge flags
    aon_exp = 32'h0;
    for (int i = 0; i < 3; i++) begin
      aon[i] <= 1'b1;
      repeat (2) @(posedge i_clk);
      aon[i] <= 1'b0;
      repeat (3) @(posedge i_clk);
      aon_exp = aon_exp | (32'h3 << (2 + 2 * i));
      rdchk(12'hd52, aon_exp);
    end
    irqchk(1'b0);
    xfer(1'b1, 12'hd54, 16'h00f8);
    irqchk(1'b1);
    xfer(1'b1, 12'hd52, 16'h0004);
    irqchk(1'b0);
    rdchk(12'hd52, 32'h000000f8);
    check("host_requests", {24'h0, irq_cnt}, 32'h4);
    // reset in mid-run: masks back to reset values, high levels count as rises
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rdchk(12'hd1d, 32'h0000ffff);
    rdchk(12'hd1f, 32'h00000000);
    rdchk(12'hd54, 32'h000000fc);
    rdchk(12'hd15, 32'h00000fff);
    rdchk(12'hd52, 32'h00000000);
    irqchk(1'b1);
    give_verdict();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 5);
    error_cnt++;
    give_verdict();
  end
endmodule
